// File: core/psram_host_ctrl.sv
// Host-side sequencer for an asynchronous pseudo-static memory
//
// How it works
// - Chip select low never exceeds eight microseconds
// - Write strobe low never exceeds eight microseconds
// - No access before power-up initialization ends
// - Sleep pin held low at least ten microseconds for power-down
// - Chip select high before sleep pin falls
// - Config load: strobe falls 10-500 ns after sleep
// - Address stable 70 ns before write end
// - Write strobe high at least 10 ns between
// - Wait 150 us after deep power-down exit
`timescale 1ns/1ps
module psram_host_ctrl
  import psram_ctrl_pkg::*;
#(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
)
(
  input logic core_clk,
  input logic rst,
  input logic req_valid,
  input op_e req_op,
  input logic [ADDR_W-1:0] req_addr,
  input logic [DATA_W-1:0] req_wdata,
  input logic [1:0] req_be,
  input logic stay_asleep,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe_n,
  input logic [DATA_W-1:0] mem_dq_in,
  output logic mem_ce_n,
  output logic mem_oe_n,
  output logic mem_we_n,
  output logic mem_lb_n,
  output logic mem_ub_n,
  output logic sleep_control_n
);

  if (ADDR_W < 8 || DATA_W != 16 || PU_CYC >= (1 << TIMER_W) || R_CYC >= (1 << TIMER_W))
  begin : g_chk
    $error("psram_host_ctrl: unsupported width or timer too narrow");
  end

  // Timer load value for a given state duration in cycles
  function automatic logic [TIMER_W-1:0] dur(input int cyc);
    return TIMER_W'(cyc - 1);
  endfunction

  timer_if #(.TW(TIMER_W)) tif ();

  cycle_timer #(.TW(TIMER_W), .RESET_COUNT(PU_CYC - 1)) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .t(tif)
  );

  state_e state;
  state_e next_state;
  op_e op;
  logic [7:0] cfg_shadow;
  logic [DATA_W-1:0] dq_s1;
  logic [DATA_W-1:0] dq_s2;
  logic [DATA_W-1:0] dq_s3;
  logic accept;
  logic agree;

  assign accept = (state == S_IDLE) && req_valid;
  assign agree = (dq_s2 == dq_s3);

  // Next state; every state but S_IDLE waits out its timer, S_RD_CAP only until the samples agree
  always_comb
  begin
    next_state = state;
    unique case (state)
      S_INIT: if (tif.done) next_state = S_IDLE;
      S_IDLE:
      begin
        if (req_valid)
        begin
          unique case (req_op)
            OP_READ: next_state = S_RD;
            OP_WRITE: next_state = S_WR;
            OP_CFG: next_state = S_CFG_DESEL;
            OP_SLEEP: next_state = S_DPD_DESEL;
          endcase
        end
      end
      S_WR: if (tif.done) next_state = S_ACC_END;
      S_RD: if (tif.done) next_state = S_RD_CAP;
      S_RD_CAP: if (agree || tif.done) next_state = S_ACC_END;
      S_ACC_END: if (tif.done) next_state = S_IDLE;
      S_CFG_DESEL: if (tif.done) next_state = S_CFG_ZZ;
      S_CFG_ZZ: if (tif.done) next_state = S_CFG_WE;
      S_CFG_WE: if (tif.done) next_state = S_ACC_END;
      S_DPD_DESEL: if (tif.done) next_state = S_DPD_LOW;
      S_DPD_LOW: if (tif.done && !stay_asleep) next_state = S_DPD_RECOV;
      S_DPD_RECOV: if (tif.done) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // Timer reload on every state change
  always_comb
  begin
    tif.load = (next_state != state);
    tif.load_val = dur(1);
    unique case (next_state)
      S_WR: tif.load_val = dur(AW_CYC);
      S_RD: tif.load_val = dur(ACCESS_CYC + SYNC_DEPTH);
      S_RD_CAP: tif.load_val = dur(RD_AGREE_CYC);
      S_ACC_END: tif.load_val = dur(WPH_CYC);
      S_CFG_DESEL: tif.load_val = dur(CDZZ_CYC);
      S_CFG_ZZ: tif.load_val = dur(ZZWE_MIN_CYC);
      S_CFG_WE: tif.load_val = dur(AW_CYC);
      S_DPD_DESEL: tif.load_val = dur(CDZZ_CYC);
      S_DPD_LOW: tif.load_val = dur(ZZ_CYC);
      // Power-down only when bit 4 was cleared, else partial refresh
      S_DPD_RECOV: tif.load_val = cfg_shadow[CFG_SLEEP_BIT] ? dur(1) : dur(R_CYC);
      default: tif.load_val = dur(1);
    endcase
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state <= S_INIT;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Request capture and configuration shadow
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      op <= OP_READ;
      mem_addr <= '0;
      mem_dq_out <= '0;
      cfg_shadow <= CFG_DEFAULT;
    end
    else if (accept)
    begin
      op <= req_op;
      mem_addr <= req_addr;
      mem_dq_out <= req_wdata;
      if (req_op == OP_CFG)
      begin
        cfg_shadow <= req_addr[7:0];
      end
    end
  end

  // Memory control pins decoded from the coming state
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      mem_ce_n <= 1'b1;
      mem_oe_n <= 1'b1;
      mem_we_n <= 1'b1;
      mem_lb_n <= 1'b1;
      mem_ub_n <= 1'b1;
      mem_dq_oe_n <= 1'b1;
      sleep_control_n <= 1'b1;
    end
    else
    begin
      mem_ce_n <= !(next_state inside {S_WR, S_RD, S_RD_CAP, S_CFG_ZZ, S_CFG_WE});
      mem_oe_n <= !(next_state inside {S_RD, S_RD_CAP});
      mem_we_n <= !(next_state inside {S_WR, S_CFG_WE});
      mem_dq_oe_n <= !(next_state == S_WR);
      mem_lb_n <= !((next_state == S_WR && req_be[0]) || next_state inside {S_RD, S_RD_CAP});
      mem_ub_n <= !((next_state == S_WR && req_be[1]) || next_state inside {S_RD, S_RD_CAP});
      sleep_control_n <= !(next_state inside {S_CFG_ZZ, S_CFG_WE, S_DPD_LOW});
      if (state == S_WR)
      begin
        mem_lb_n <= mem_lb_n;
        mem_ub_n <= mem_ub_n;
      end
    end
  end

  // Read data synchroniser, three stages
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      dq_s3 <= '0;
    end
    else
    begin
      dq_s1 <= mem_dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end

  // User handshake and read answer
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
    end
    else
    begin
      req_ready <= (next_state == S_IDLE);
      rsp_valid <= (state == S_RD_CAP) && (next_state != S_RD_CAP);
      if ((state == S_RD_CAP) && (next_state != S_RD_CAP))
      begin
        rsp_data <= dq_s3;
      end
    end
  end

  // Checking helpers: saturating low-time and quiet-time counters
  function automatic logic [TIMER_W-1:0] sat_inc(input logic [TIMER_W-1:0] v);
    return (v == '1) ? v : v + 1'b1;
  endfunction

  logic [TIMER_W-1:0] ce_lo;
  logic [TIMER_W-1:0] we_lo;
  logic [TIMER_W-1:0] zz_lo;
  logic [TIMER_W-1:0] quiet;
  logic woke;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ce_lo <= '0;
      we_lo <= '0;
      zz_lo <= '0;
      quiet <= '0;
      woke <= 1'b0;
    end
    else
    begin
      ce_lo <= mem_ce_n ? '0 : sat_inc(ce_lo);
      we_lo <= mem_we_n ? '0 : sat_inc(we_lo);
      zz_lo <= sleep_control_n ? '0 : sat_inc(zz_lo);
      quiet <= sat_inc(quiet);
      if (state == S_DPD_LOW && next_state == S_DPD_RECOV && !cfg_shadow[CFG_SLEEP_BIT])
      begin
        quiet <= '0;
        woke <= 1'b1;
      end
    end
  end

  localparam int A_ZZWE_LO = ZZWE_MIN_CYC;
  localparam int A_ZZWE_HI = ZZWE_MAX_CYC;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_ce_max;
    !mem_ce_n |-> ce_lo < TIMER_W'(CEM_CYC);
  endproperty
  a_ce_max: assert property (p_ce_max) else $error("chip select low too long");

  property p_we_max;
    !mem_we_n |-> we_lo < TIMER_W'(CEM_CYC);
  endproperty
  a_we_max: assert property (p_we_max) else $error("write strobe low too long");

  property p_init_wait;
    (!mem_ce_n && !woke) |-> quiet >= TIMER_W'(PU_CYC);
  endproperty
  a_init_wait: assert property (p_init_wait) else $error("access before init");

  // A configuration load also pulses the sleep pin, but with the strobe low; only a
  // pulse with the strobe idle to its end is a power-down pulse bound by the width
  property p_sleep_width;
    ($rose(sleep_control_n) && mem_ce_n && $past(mem_we_n)) |->
      $past(zz_lo) >= TIMER_W'(ZZ_CYC - 1);
  endproperty
  a_sleep_width: assert property (p_sleep_width) else $error("sleep pulse short");

  property p_desel_first;
    $fell(sleep_control_n) |-> $past(mem_ce_n);
  endproperty
  a_desel_first: assert property (p_desel_first) else $error("select low at sleep");

  property p_zz_to_we;
    ($fell(sleep_control_n) && !mem_ce_n) |-> mem_we_n ##[A_ZZWE_LO:A_ZZWE_HI] !mem_we_n;
  endproperty
  a_zz_to_we: assert property (p_zz_to_we) else $error("strobe not in window");

  property p_addr_valid;
    $fell(mem_we_n) |-> !mem_we_n ##1 (!mem_we_n && $stable(mem_addr)) ##1
      (mem_we_n && $stable(mem_addr));
  endproperty
  a_addr_valid: assert property (p_addr_valid) else $error("address window short");

  property p_we_high;
    $rose(mem_we_n) |=> mem_we_n;
  endproperty
  a_we_high: assert property (p_we_high) else $error("strobe high too short");

  property p_recovery;
    (!mem_ce_n && woke) |-> quiet >= TIMER_W'(R_CYC);
  endproperty
  a_recovery: assert property (p_recovery) else $error("access during recovery");

  property p_cfg_write;
    (!mem_we_n && !sleep_control_n) |-> !mem_ce_n && mem_oe_n && mem_addr[7:0] == cfg_shadow;
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("bad config write");

endmodule

// File: common/psram_ctrl_pkg.sv
// Constants, timing counts and enumerations for the pseudo-static memory controller
package psram_ctrl_pkg;

  // Core clock rate
  localparam int CLK_MHZ = 20;

  // Least time in ns to whole cycles, rounded up, never below one
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time in ns to whole cycles, rounded down, never below one
  function automatic int cyc_max(input int ns);
    int c;
    c = (ns * CLK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // Memory timing figures as printed
  localparam int ACCESS_NS = 70;
  localparam int ADDRESS_VALID_TO_WRITE_END_NS = 70;
  localparam int WRITE_HIGH_MIN_TIME_NS = 10;
  localparam int DESELECT_TO_SLEEP_LOW_NS = 5;
  localparam int SLEEP_LOW_TO_WRITE_LOW_MIN_NS = 10;
  localparam int SLEEP_LOW_TO_WRITE_LOW_MAX_NS = 500;
  localparam int SLEEP_PULSE_MIN_WIDTH_US = 10;
  localparam int POWERUP_INIT_TIME_US = 150;
  localparam int POWERDOWN_RECOVERY_TIME_US = 150;
  localparam int MAX_SELECT_LOW_TIME_US = 8;

  // Cycle counts derived from the figures
  localparam int ACCESS_CYC = cyc_min(ACCESS_NS);
  localparam int AW_CYC = cyc_min(ADDRESS_VALID_TO_WRITE_END_NS);
  localparam int WPH_CYC = cyc_min(WRITE_HIGH_MIN_TIME_NS);
  localparam int CDZZ_CYC = cyc_min(DESELECT_TO_SLEEP_LOW_NS);
  localparam int ZZWE_MIN_CYC = cyc_min(SLEEP_LOW_TO_WRITE_LOW_MIN_NS);
  localparam int ZZWE_MAX_CYC = cyc_max(SLEEP_LOW_TO_WRITE_LOW_MAX_NS);
  localparam int ZZ_CYC = cyc_min(SLEEP_PULSE_MIN_WIDTH_US * 1000);
  localparam int PU_CYC = cyc_min(POWERUP_INIT_TIME_US * 1000);
  localparam int R_CYC = cyc_min(POWERDOWN_RECOVERY_TIME_US * 1000);
  localparam int CEM_CYC = cyc_max(MAX_SELECT_LOW_TIME_US * 1000);

  // Read data synchroniser depth and extra wait for agreement
  localparam int SYNC_DEPTH = 3;
  localparam int RD_AGREE_CYC = 3;

  // Timer width
  localparam int TIMER_W = 12;

  // Configuration register layout and power-up default
  localparam int CFG_SLEEP_BIT = 4;
  localparam logic [7:0] CFG_DEFAULT = 8'h70;

  // User commands
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_CFG = 2'h2,
    OP_SLEEP = 2'h3
  } op_e;

  // Sequencer states, codes step in Gray order as listed
  typedef enum logic [3:0] {
    S_INIT = 4'h0,
    S_IDLE = 4'h1,
    S_WR = 4'h3,
    S_RD = 4'h2,
    S_RD_CAP = 4'h6,
    S_ACC_END = 4'h7,
    S_CFG_DESEL = 4'h5,
    S_CFG_ZZ = 4'h4,
    S_CFG_WE = 4'hc,
    S_DPD_DESEL = 4'hd,
    S_DPD_LOW = 4'hf,
    S_DPD_RECOV = 4'he
  } state_e;

endpackage

// File: common/timer_if.sv
// Load and done signals between the sequencer and its duration timer
`timescale 1ns/1ps
interface timer_if #(parameter int TW = 12);
  logic load;
  logic [TW-1:0] load_val;
  logic done;

  modport ctl (output load, output load_val, input done);
  modport tmr (input load, input load_val, output done);
endinterface

// File: core/cycle_timer.sv
// Down counter that times each sequencer state
`timescale 1ns/1ps
module cycle_timer
  import psram_ctrl_pkg::*;
#(
  parameter int TW = 12,
  parameter int RESET_COUNT = 0
)
(
  input logic core_clk,
  input logic rst,
  timer_if.tmr t
);

  if (RESET_COUNT >= (1 << TW) || RESET_COUNT < 0)
  begin : g_chk
    $error("cycle_timer: reset count does not fit the counter");
  end

  logic [TW-1:0] count;

  // Load on request, else count down to zero and hold
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      count <= TW'(RESET_COUNT);
    end
    else if (t.load)
    begin
      count <= t.load_val;
    end
    else if (count != '0)
    begin
      count <= count - 1'b1;
    end
  end

  assign t.done = (count == '0);

endmodule

// File: tb/psram_model.sv
// Behavioural pseudo-static memory that answers the controller and tallies timing faults
`timescale 1ns/1ps
module psram_model
  import psram_ctrl_pkg::*;
#(
  parameter int RD_LAT = 2
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [21:0] mem_addr,
  input wire logic [15:0] mem_dq_out,
  input wire logic mem_dq_oe_n,
  input wire logic mem_ce_n,
  input wire logic mem_oe_n,
  input wire logic mem_we_n,
  input wire logic mem_lb_n,
  input wire logic mem_ub_n,
  input wire logic sleep_control_n,
  output logic [15:0] mem_dq_q,
  output logic [7:0] viol
);
  logic [15:0] mem [0:255];
  logic [7:0] cfg;
  logic [21:0] p_addr;
  logic p_we_n, p_zz_n, cfg_seen, rd_on;
  int pu_cnt, rec_cnt, ce_lo, ce_hi, we_lo, we_hi, zz_lo, oe_lo, addr_st;

  initial viol = 8'h00;
  initial mem_dq_q = 16'h0000;
  assign rd_on = !mem_ce_n && !mem_oe_n && sleep_control_n;

  // Pin history, timing counters, storage and fault tally
  always @(posedge core_clk)
  begin
    int f;
    f = 0;
    mem_dq_q <= (rd_on && oe_lo + 1 >= RD_LAT) ? mem[mem_addr[7:0]] : ~mem_dq_q;
    if (rst)
    begin
      pu_cnt <= 0;
      rec_cnt <= 0;
      cfg <= CFG_DEFAULT;
      p_we_n <= 1'b1;
      p_zz_n <= 1'b1;
      cfg_seen <= 1'b0;
      {ce_lo, we_lo, zz_lo, oe_lo, addr_st} <= '0;
      ce_hi <= CDZZ_CYC;
      we_hi <= WPH_CYC;
    end
    else
    begin
      pu_cnt <= (pu_cnt < PU_CYC) ? pu_cnt + 1 : pu_cnt;
      rec_cnt <= (rec_cnt > 0) ? rec_cnt - 1 : 0;
      if (!mem_ce_n && sleep_control_n && (pu_cnt < PU_CYC || rec_cnt > 0))
        f++;
      if (!mem_ce_n && ce_lo >= CEM_CYC)
        f++;
      if (!mem_we_n && we_lo >= CEM_CYC)
        f++;
      if (p_zz_n && !sleep_control_n && ce_hi < CDZZ_CYC)
        f++;
      if (p_we_n && !mem_we_n && we_hi < WPH_CYC)
        f++;
      if (p_we_n && !mem_we_n && !sleep_control_n && (zz_lo < ZZWE_MIN_CYC || zz_lo > ZZWE_MAX_CYC))
        f++;
      if (!p_we_n && mem_we_n && addr_st < AW_CYC)
        f++;
      if (!mem_we_n && !sleep_control_n && mem_ce_n)
        f++;
      if (!mem_we_n && !sleep_control_n && !mem_ce_n)
        cfg <= mem_addr[7:0];
      if (!mem_we_n && sleep_control_n && !mem_ce_n && !mem_dq_oe_n && !mem_lb_n)
        mem[mem_addr[7:0]][7:0] <= mem_dq_out[7:0];
      if (!mem_we_n && sleep_control_n && !mem_ce_n && !mem_dq_oe_n && !mem_ub_n)
        mem[mem_addr[7:0]][15:8] <= mem_dq_out[15:8];
      if (!p_zz_n && sleep_control_n && !cfg_seen)
      begin
        if (zz_lo < ZZ_CYC)
          f++;
        if (!cfg[CFG_SLEEP_BIT])
        begin
          rec_cnt <= R_CYC;
          for (int i = 0; i < 256; i++)
            mem[i] <= 16'hdead;
        end
      end
      cfg_seen <= sleep_control_n ? 1'b0 : (cfg_seen || (p_we_n && !mem_we_n));
      ce_lo <= mem_ce_n ? 0 : ce_lo + 1;
      ce_hi <= mem_ce_n ? ce_hi + 1 : 0;
      we_lo <= mem_we_n ? 0 : we_lo + 1;
      we_hi <= mem_we_n ? we_hi + 1 : 0;
      zz_lo <= sleep_control_n ? 0 : zz_lo + 1;
      oe_lo <= rd_on ? oe_lo + 1 : 0;
      addr_st <= (mem_addr == p_addr) ? addr_st + 1 : 1;
      p_we_n <= mem_we_n;
      p_zz_n <= sleep_control_n;
      viol <= viol + 8'(f);
    end
    p_addr <= mem_addr;
  end
endmodule

// File: tb/psram_host_ctrl_tb_top.sv
// Self-checking bench for the memory controller against a behavioural memory
`timescale 1ns/1ps
module psram_host_ctrl_tb_top;
  import psram_ctrl_pkg::*;
  typedef struct {op_e op; logic [21:0] a; logic [15:0] d; logic [1:0] be; logic [15:0] x;} row_s;
  localparam int LIMIT = 20000;
  logic core_clk, rst, req_valid, stay_asleep, req_ready, rsp_valid, mem_dq_oe_n;
  logic mem_ce_n, mem_oe_n, mem_we_n, mem_lb_n, mem_ub_n, sleep_control_n;
  op_e req_op;
  logic [21:0] req_addr, mem_addr;
  logic [15:0] req_wdata, rsp_data, mem_dq_out, mem_dq_q, dq_wire, rd;
  logic [1:0] req_be;
  logic [7:0] viol;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int n, w;
  row_s rows [8];

  // Wire level: controller drives while its enable is low
  assign dq_wire = mem_dq_oe_n ? mem_dq_q : mem_dq_out;

  psram_host_ctrl i_psram_host_ctrl (.core_clk, .rst, .req_valid, .req_op, .req_addr,
    .req_wdata, .req_be, .stay_asleep, .req_ready, .rsp_valid, .rsp_data, .mem_addr,
    .mem_dq_out, .mem_dq_oe_n, .mem_dq_in(dq_wire), .mem_ce_n, .mem_oe_n, .mem_we_n,
    .mem_lb_n, .mem_ub_n, .sleep_control_n);
  psram_model i_psram_model (.core_clk, .rst, .mem_addr, .mem_dq_out, .mem_dq_oe_n,
    .mem_ce_n, .mem_oe_n, .mem_we_n, .mem_lb_n, .mem_ub_n, .sleep_control_n, .mem_dq_q, .viol);

  // Clock
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Cycle ceiling against a hung sequence
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_errors = n_errors + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task automatic wait_ready(output int k);
    k = 0;
    while (req_ready !== 1'b1 && k < 5000)
    begin
      tick(1);
      k++;
    end
  endtask

  // One request held until taken, read answer collected
  task automatic do_req(input op_e op, input logic [21:0] a, input logic [15:0] d,
    input logic [1:0] be, output logic [15:0] q);
    int k;
    wait_ready(k);
    req_valid = 1'b1;
    req_op = op;
    req_addr = a;
    req_wdata = d;
    req_be = be;
    tick(1);
    req_valid = 1'b0;
    q = 16'hxxxx;
    k = 0;
    while (op == OP_READ && rsp_valid !== 1'b1 && k < 20)
    begin
      tick(1);
      k++;
    end
    if (op == OP_READ)
      q = rsp_data;
  endtask

  // Sleep pulse: low width, then wait until ready again
  task automatic sleep_run(input int hold, output int wd, output int r);
    logic [15:0] q;
    stay_asleep = (hold > 0);
    do_req(OP_SLEEP, 22'h0, 16'h0, 2'h0, q);
    wd = 0;
    while (sleep_control_n !== 1'b0 && wd < 10)
    begin
      tick(1);
      wd++;
    end
    wd = 0;
    while (sleep_control_n === 1'b0 && wd < 2000)
    begin
      tick(1);
      wd++;
      if (wd == hold)
        stay_asleep = 1'b0;
    end
    wait_ready(r);
  endtask

  initial
  begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_op = OP_READ;
    req_addr = 22'h0;
    req_wdata = 16'h0;
    req_be = 2'h0;
    stay_asleep = 1'b0;
    rows = '{'{OP_WRITE, 22'h10, 16'h1234, 2'h3, 16'h0}, '{OP_WRITE, 22'h11, 16'habcd, 2'h3, 16'h0},
      '{OP_WRITE, 22'h10, 16'hff00, 2'h2, 16'h0}, '{OP_WRITE, 22'h11, 16'h0077, 2'h1, 16'h0},
      '{OP_READ, 22'h10, 16'h0, 2'h0, 16'hff34}, '{OP_READ, 22'h11, 16'h0, 2'h0, 16'hab77},
      '{OP_WRITE, 22'h3ff, 16'h0f0f, 2'h3, 16'h0}, '{OP_READ, 22'h3ff, 16'h0, 2'h0, 16'h0f0f}};
    tick(8);
    check("ready_in_reset", req_ready, 0);
    check("pins_in_reset", {mem_ce_n, mem_we_n, mem_oe_n, sleep_control_n}, 4'hf);
    rst = 1'b0;
    wait_ready(n);
    check("powerup_wait", n >= PU_CYC, 1);
    // Plain writes with lane selects and back-to-back reads
    foreach (rows[i])
    begin
      do_req(rows[i].op, rows[i].a, rows[i].d, rows[i].be, rd);
      if (rows[i].op == OP_READ)
        check("row_read", rd, rows[i].x);
    end
    // Deep power-down chosen by configuration
    do_req(OP_CFG, 22'h60, 16'h0, 2'h0, rd);
    wait_ready(n);
    check("cfg_loaded", i_psram_model.cfg, 8'h60);
    sleep_run(300, w, n);
    check("dpd_width", w >= 300, 1);
    check("dpd_recovery", n >= R_CYC, 1);
    // Partial refresh keeps data and needs no recovery
    do_req(OP_CFG, 22'h70, 16'h0, 2'h0, rd);
    do_req(OP_WRITE, 22'h11, 16'h5a5a, 2'h3, rd);
    sleep_run(0, w, n);
    check("par_width", w >= ZZ_CYC, 1);
    check("par_recovery", n < 10, 1);
    do_req(OP_READ, 22'h11, 16'h0, 2'h0, rd);
    check("par_keeps_data", rd, 16'h5a5a);
    // Reset in the middle of a write
    wait_ready(n);
    req_valid = 1'b1;
    req_op = OP_WRITE;
    tick(2);
    rst = 1'b1;
    req_valid = 1'b0;
    tick(2);
    check("pins_mid_reset", {mem_ce_n, mem_we_n, sleep_control_n, req_ready}, 4'he);
    rst = 1'b0;
    wait_ready(n);
    check("powerup_wait_again", n >= PU_CYC, 1);
    check("model_faults", viol, 0);
    finish_test();
  end
endmodule
